// File: bench/pic_chk.sv
// Port checker for pic_ctrl.
// Bound from the testbench; one clock, synchronous reset.
module pic_chk #(
  parameter int N = 32
) (
  input wire logic                                clk,
  input wire logic                                reset,
  input wire logic                                ack,
  input wire logic                                eoi,
  input wire logic                                irq,
  input wire logic                                irq_n,
  input wire logic                                fast_irq,
  input wire logic                                fast_irq_n,
  input wire logic [pic_pkg::PIC_ID_W-1:0]        irq_code,
  input wire logic [pic_pkg::PIC_ID_W-1:0]        fast_sel,
  input wire logic [pic_pkg::PIC_ID_W-1:0]        cur_id,
  input wire logic [pic_pkg::PIC_PRIO_W-1:0]      irq_level,
  input wire logic [N-1:0]                        pending,
  input wire logic [N-1:0]                        src_enable,
  input wire logic [N-1:0]                        src_mask,
  input wire logic [pic_pkg::PIC_NUM_LEVELS-1:0]  in_service
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [N-1:0] ok_q;
  always_ff @(posedge clk) begin
    ok_q <= src_enable & ~src_mask;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  chk_irq_pair: assert property (irq_n == !irq) else $error("irq pair");
  chk_fast_pair: assert property (fast_irq_n == !fast_irq) else $error("fast pair");
  chk_irq_source: assert property (irq |-> ok_q[irq_code]) else $error("irq source");
  chk_fast_follow: assert property
    (fast_irq == $past(pending[fast_sel] && src_enable[fast_sel] && !src_mask[fast_sel])) else $error("fast");
  chk_ack_id: assert property (ack && irq |=> cur_id == $past(irq_code)) else $error("ack id");
  chk_ack_level: assert property (ack && irq |=> in_service[$past(irq_level)]) else $error("ack lvl");
  chk_nest_thresh: assert property (irq && !$past(ack) |-> (in_service >> irq_level) == 0) else $error("nest");
  chk_eoi_drop: assert property
    (eoi && !ack && in_service != 0 |=> in_service < $past(in_service)) else $error("eoi");
  chk_no_pend_dis: assert property
    ((pending & ~$past(pending) & ~$past(src_enable)) == 0) else $error("disabled pend");
endmodule : pic_chk

// File: bench/pic_cpu.sv
// Processor-side model: takes the normal request and ends service.
// Pulses are launched at the falling edge and last one cycle.
module pic_cpu (
  input  wire logic clk,
  input  wire logic irq,
  output logic      ack,
  output logic      eoi
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ack = 1'b0;
    eoi = 1'b0;
  end
  // Two idle cycles after each pulse, since the request is one cycle stale after a take
  task automatic take();
    for (int n = 0; n < 20 && irq !== 1'b1; n++) @(negedge clk);
    ack = 1'b1;
    @(negedge clk);
    ack = 1'b0;
    repeat (2) @(negedge clk);
  endtask : take
  task automatic finish();
    eoi = 1'b1;
    @(negedge clk);
    eoi = 1'b0;
    repeat (2) @(negedge clk);
  endtask : finish
endmodule : pic_cpu

// File: bench/testbench.sv
// Self-checking bench for pic_ctrl with eight sources.
// Assumes pic_cpu and pic_chk are compiled first.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int N = 8;
  logic clk = 1'b0, reset = 1'b1, fast_clear = 1'b0, ack, eoi, irq, irq_n, fast_irq, fast_irq_n, cur_valid;
  logic [N-1:0] src_in = '0, sw_sel = '1, sw_req = '0, src_enable = '1, src_mask = '0, pending;
  logic [2*N-1:0] trig_type = '0;
  logic [3*N-1:0] src_prio = 24'h1E8158;
  logic [pic_pkg::PIC_ID_W-1:0] fast_sel = 5'h07, irq_code, cur_id;
  logic [2:0] irq_level;
  logic [7:0] in_service;
  int err_count = 0, n_checks = 0;
  always #2 clk = ~clk;
  pic_ctrl #(
    .N (N)
  ) i_pic_ctrl (
    .clk        (clk),
    .reset      (reset),
    .src_in     (src_in),
    .sw_sel     (sw_sel),
    .sw_req     (sw_req),
    .src_enable (src_enable),
    .src_mask   (src_mask),
    .trig_type  (trig_type),
    .src_prio   (src_prio),
    .fast_sel   (fast_sel),
    .ack        (ack),
    .eoi        (eoi),
    .fast_clear (fast_clear),
    .irq        (irq),
    .irq_n      (irq_n),
    .irq_code   (irq_code),
    .irq_level  (irq_level),
    .fast_irq   (fast_irq),
    .fast_irq_n (fast_irq_n),
    .cur_id     (cur_id),
    .cur_valid  (cur_valid),
    .pending    (pending),
    .in_service (in_service)
  );
  pic_cpu i_pic_cpu (.clk(clk), .irq(irq), .ack(ack), .eoi(eoi));
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic pulse(int i);
    sw_req[i] = 1'b1;
    cyc(1);
    sw_req[i] = 1'b0;
    cyc(3);
  endtask : pulse
  task automatic serve(logic [4:0] id, logic [2:0] lvl);
    check("irq pair", {irq, irq_n}, 2'h2);
    check("level code", {irq_level, irq_code}, {lvl, id});
    i_pic_cpu.take();
    check("cur_id", cur_id, id);
    check("cur_valid", cur_valid, 1'b1);
    i_pic_cpu.finish();
    cyc(1);
  endtask : serve
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    #20000;
    err_count++;
    give_verdict();
  end
  // Priorities: src1 3, src2 5, src5 5, src6 7, the rest 0
  initial begin
    cyc(8);
    reset = 1'b0;
    sw_req = 8'h26;
    cyc(1);
    sw_req = '0;
    cyc(3);
    serve(5'h02, 3'h5);
    serve(5'h05, 3'h5);
    i_pic_cpu.take();
    pulse(6);
    serve(5'h06, 3'h7);
    i_pic_cpu.finish();
    check("in_service", in_service, 8'h00);
    check("cur_valid idle", cur_valid, 1'b0);
    $display("priority test done");
    src_mask[4] = 1'b1;
    pulse(4);
    check("masked", {pending[4], irq}, 2'h2);
    src_mask[4] = 1'b0;
    cyc(3);
    serve(5'h04, 3'h0);
    src_enable[3] = 1'b0;
    pulse(3);
    check("disabled", {pending[3], irq}, 2'h0);
    pulse(7);
    check("fast", {fast_irq, fast_irq_n, irq}, 3'h4);
    fast_clear = 1'b1;
    cyc(1);
    fast_clear = 1'b0;
    cyc(2);
    check("fast clear", fast_irq, 1'b0);
    $display("mask and fast test done");
    sw_sel[0] = 1'b0;
    for (int t = 0; t < 4; t++) begin
      src_enable[0] = 1'b0;
      trig_type[1:0] = t[1:0];
      src_in[0] = t[0];
      cyc(5);
      src_enable[0] = 1'b1;
      cyc(5);
      check("idle", pending[0], 1'b0);
      src_in[0] = !t[0];
      cyc(2);
      src_in[0] = t[0];
      cyc(4);
      serve(5'h00, 3'h0);
    end
    $display("trigger test done");
    give_verdict();
  end
endmodule : testbench
bind pic_ctrl pic_chk #(
  .N (N)
) i_pic_chk (
  .clk        (clk),
  .reset      (reset),
  .ack        (ack),
  .eoi        (eoi),
  .irq        (irq),
  .irq_n      (irq_n),
  .fast_irq   (fast_irq),
  .fast_irq_n (fast_irq_n),
  .irq_code   (irq_code),
  .fast_sel   (fast_sel),
  .cur_id     (cur_id),
  .irq_level  (irq_level),
  .pending    (pending),
  .src_enable (src_enable),
  .src_mask   (src_mask),
  .in_service (in_service)
);

// File: src/pic_ctrl.sv
// Prioritised interrupt controller: pending store, priority arbitration, nesting and fast path.
// Coded normal request and a separate fast request pair, both straight from registers.
// Assumes software-side controls are synchronous to clk; hardware sources go through pic_detect.
module pic_ctrl #(
  parameter int N = 32
) (
  input  wire logic                        clk,
  input  wire logic                        reset,
  input  wire logic [N-1:0]                src_in,
  input  wire logic [N-1:0]                sw_sel,
  input  wire logic [N-1:0]                sw_req,
  input  wire logic [N-1:0]                src_enable,
  input  wire logic [N-1:0]                src_mask,
  input  wire logic [2*N-1:0]              trig_type,
  input  wire logic [3*N-1:0]              src_prio,
  input  wire logic [pic_pkg::PIC_ID_W-1:0] fast_sel,
  input  wire logic                        ack,
  input  wire logic                        eoi,
  input  wire logic                        fast_clear,
  output logic                             irq,
  output logic                             irq_n,
  output logic [pic_pkg::PIC_ID_W-1:0]     irq_code,
  output logic [pic_pkg::PIC_PRIO_W-1:0]   irq_level,
  output logic                             fast_irq,
  output logic                             fast_irq_n,
  output logic [pic_pkg::PIC_ID_W-1:0]     cur_id,
  output logic                             cur_valid,
  output logic [N-1:0]                     pending,
  output logic [pic_pkg::PIC_NUM_LEVELS-1:0] in_service
);
  localparam int IW = pic_pkg::PIC_ID_W;
  localparam int PW = pic_pkg::PIC_PRIO_W;
  localparam int LV = pic_pkg::PIC_NUM_LEVELS;
  // Sources past the coded range keep detection and a pending bit but are never arbitrated, whatever N says
  localparam int NI = (N < pic_pkg::PIC_MAX_SRC) ? N : pic_pkg::PIC_MAX_SRC;

  typedef struct packed {
    logic [N-1:0]  pend;
    logic [LV-1:0] insvc;
    logic          req;
    logic [IW-1:0] code;
    logic [PW-1:0] code_prio;
    logic [IW-1:0] cur;
    logic          fast;
  } pic_state_s;

  pic_state_s st;
  pic_state_s next_st;

  logic [N-1:0]  detect;
  logic [N-1:0]  live;
  logic [N-1:0]  cand;
  logic [N-1:0]  fast_onehot;
  logic [N-1:0]  take_hot;
  logic          win_valid;
  logic [IW-1:0] win_id;
  logic [PW-1:0] win_prio;
  logic          svc_busy;
  logic [PW-1:0] svc_level;
  logic          take_ev;
  logic          end_ev;

  // Highest set level; used for the nesting threshold and for end of service
  function automatic logic [PW:0] top_level(input logic [LV-1:0] v);
    logic [PW:0] r;
    r = '0;
    for (int l = 0; l < LV; l++) begin
      if (v[l]) begin
        r = {1'b1, PW'(l)};
      end
    end
    return r;
  endfunction : top_level

  // One-hot decode of a source index; an index past the last built source gives zero
  function automatic logic [N-1:0] onehot_of(input logic [IW-1:0] id);
    logic [N-1:0] r;
    r = '0;
    for (int i = 0; i < NI; i++) begin
      r[i] = (id == IW'(i));
    end
    return r;
  endfunction : onehot_of

  // Priority field of one source
  function automatic logic [PW-1:0] prio_of(input logic [3*N-1:0] fields, input int i);
    return fields[PW*i +: PW];
  endfunction : prio_of

  pic_detect #(
    .N (N)
  ) u_detect (
    .clk       (clk),
    .reset     (reset),
    .src_in    (src_in),
    .sw_sel    (sw_sel),
    .sw_req    (sw_req),
    .trig_type (trig_type),
    .detect    (detect)
  );

  // Unbuilt source slots stay tied off, so nothing past NI reaches a request
  for (genvar g = 0; g < N; g++) begin : g_src
    if (g < NI) begin : g_used
      assign live[g] = st.pend[g] & src_enable[g] & ~src_mask[g];
    end else begin : g_unused
      assign live[g] = 1'b0;
    end
  end

  always_comb begin
    logic [PW:0] lvl;
    lvl         = top_level(st.insvc);
    svc_busy    = lvl[PW];
    svc_level   = lvl[PW-1:0];
    fast_onehot = onehot_of(fast_sel);

    // Fast source is kept out of arbitration so it is never serviced twice
    cand        = live & ~fast_onehot;
    win_valid   = 1'b0;
    win_id      = pic_pkg::PIC_ID_RST;
    win_prio    = pic_pkg::PIC_PRIO_RST;

    for (int i = 0; i < NI; i++) begin
      // Strictly greater keeps the lowest index among equals
      if (cand[i] && (!win_valid || prio_of(src_prio, i) > win_prio)) begin
        win_valid = 1'b1;
        win_id    = IW'(i);
        win_prio  = prio_of(src_prio, i);
      end
    end
  end

  // A take needs a standing request; an end of service needs a level in service
  assign take_ev  = ack && st.req;
  assign end_ev   = eoi && svc_busy;
  assign take_hot = onehot_of(st.code);

  always_comb begin
    next_st = st;

    // End of service clears the highest level in service
    if (end_ev) begin
      next_st.insvc[svc_level] = 1'b0;
    end

    // Service start comes after the clear, so a level set in the same cycle survives
    if (take_ev) begin
      next_st.pend                = next_st.pend & ~take_hot;
      next_st.insvc[st.code_prio] = 1'b1;
      next_st.cur                 = st.code;
    end

    if (fast_clear) begin
      next_st.pend = next_st.pend & ~fast_onehot;
    end

    // Set wins over clear, so a new event in the clearing cycle is kept
    next_st.pend = next_st.pend | (detect & src_enable);

    // Request only above the level in service, which gives nesting
    next_st.req       = win_valid && (!svc_busy || win_prio > svc_level);
    next_st.code      = win_valid ? win_id : st.code;
    next_st.code_prio = win_valid ? win_prio : st.code_prio;
    next_st.fast      = |(live & fast_onehot);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st.pend      <= '0;
      st.insvc     <= pic_pkg::PIC_INSVC_RST;
      st.req       <= 1'b0;
      st.code      <= pic_pkg::PIC_ID_RST;
      st.code_prio <= pic_pkg::PIC_PRIO_RST;
      st.cur       <= pic_pkg::PIC_ID_RST;
      st.fast      <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign irq        = st.req;
  assign irq_n      = ~st.req;
  assign irq_code   = st.code;
  assign irq_level  = st.code_prio;
  assign fast_irq   = st.fast;
  assign fast_irq_n = ~st.fast;
  assign cur_id     = st.cur;
  assign cur_valid  = svc_busy;
  assign pending    = st.pend;
  assign in_service = st.insvc;
endmodule : pic_ctrl

// File: src/pic_detect.sv
// Source front end: synchroniser, hardware/software select and trigger detection.
// Assumes hardware source inputs are asynchronous to clk.
module pic_detect #(
  parameter int N = 32
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [N-1:0]     src_in,
  input  wire logic [N-1:0]     sw_sel,
  input  wire logic [N-1:0]     sw_req,
  input  wire logic [2*N-1:0]   trig_type,
  output logic      [N-1:0]     detect
);
  typedef struct packed {
    logic [N-1:0] s1;
    logic [N-1:0] s2;
    logic [N-1:0] prev;
  } pic_det_s;

  pic_det_s st;
  pic_det_s next_st;

  always_comb begin
    next_st      = st;
    next_st.s1   = src_in;
    next_st.s2   = st.s1;
    next_st.prev = st.s2;
    for (int i = 0; i < N; i++) begin
      if (sw_sel[i]) begin
        detect[i] = sw_req[i];
      end else begin
        case (trig_type[2*i +: 2])
          pic_pkg::PIC_TRIG_RISE: detect[i] = st.s2[i] & ~st.prev[i];
          pic_pkg::PIC_TRIG_FALL: detect[i] = ~st.s2[i] & st.prev[i];
          pic_pkg::PIC_TRIG_HIGH: detect[i] = st.s2[i];
          default:                detect[i] = ~st.s2[i];
        endcase
      end
    end
  end

  // Prev starts at zero, so a source held high through reset looks like a rising edge
  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : pic_detect

// File: src/pic_pkg.sv
// Shared constants of the prioritised interrupt controller.
// Assumes a single clock domain and a synchronous active-high reset.
package pic_pkg;
  localparam int          PIC_MAX_SRC    = 32;
  localparam int          PIC_ID_W       = 5;
  localparam int          PIC_PRIO_W     = 3;
  localparam int          PIC_NUM_LEVELS = 8;
  localparam logic [1:0]  PIC_TRIG_RISE  = 2'h0;
  localparam logic [1:0]  PIC_TRIG_FALL  = 2'h1;
  localparam logic [1:0]  PIC_TRIG_HIGH  = 2'h2;
  localparam logic [1:0]  PIC_TRIG_LOW   = 2'h3;
  localparam logic [7:0]  PIC_INSVC_RST  = 8'h00;
  localparam logic [4:0]  PIC_ID_RST     = 5'h00;
  localparam logic [2:0]  PIC_PRIO_RST   = 3'h0;
  localparam int          PIC_SYNC_CYC   = 2;
endpackage : pic_pkg
